/* pkg/cvl_cfg.svh */
// Purpose: constants of the convolver control port and cascade path
// Assumes: included by bare name in cvl_dev, cvl_host and the bench; cvl_monitor writes its address codes as literals
// Notes: register address codes, reset values, field positions, counts
`ifndef CVL_CFG_SVH
`define CVL_CFG_SVH

`define CVL_ADDR_ROW_LEN 3'h0
`define CVL_ADDR_ALU_CMD 3'h1
`define CVL_ADDR_COEF0 3'h2
`define CVL_ADDR_COEF1 3'h3
`define CVL_ADDR_INIT 3'h4
`define CVL_ADDR_SEL0 3'h5
`define CVL_ADDR_SEL1 3'h6
`define CVL_ADDR_NOP 3'h7

`define CVL_ROW_LEN_RST 10'h000
`define CVL_ALU_CMD_RST 10'h018
`define CVL_INIT_RST 9'h000
`define CVL_COEF_RST 8'h00

`define CVL_INIT_CASCADE_MODE 0
`define CVL_INIT_SHIFT_LO 7
`define CVL_INIT_SHIFT_HI 8

`define CVL_KERNEL_TAPS 9
`define CVL_LAST_TAP 4'h8

`define CVL_SETUP_CYC 3'h1
`define CVL_STROBE_CYC 3'h2

`endif

/* pkg/cvl_if.sv */
// Purpose: configuration write port between processor and convolver
// Assumes: both ends clocked by i_core_clk
// Notes: strobes are active low, no clocking block
interface cvl_if;
	logic [2:0] register_address;
	logic [9:0] config_input_bus;
	logic chip_select_n;
	logic load_strobe_n;

	modport dev (
		input register_address,
		input config_input_bus,
		input chip_select_n,
		input load_strobe_n
	);

	modport host (
		output register_address,
		output config_input_bus,
		output chip_select_n,
		output load_strobe_n
	);
endinterface

/* pkg/cvl_pkg.sv */
// Purpose: shared types of the convolver control port
// Assumes: constants live in cvl_cfg.svh
// Notes: host sequencer states are kept here for cvl_host
package cvl_pkg;
	typedef logic [7:0] cvl_pix_t;
	typedef logic [2:0] cvl_addr_t;
	typedef logic [9:0] cvl_data_t;
	typedef enum logic [1:0] {
		CVL_IDLE,
		CVL_SETUP,
		CVL_STROBE,
		CVL_HOLD
	} cvl_host_state_e;
endpackage

/* src/cvl_dev.sv */
// Purpose: convolver control registers and cascade datapath
// Assumes: write port driven by logic on i_core_clk
// Notes: multiplier array and ALU sit outside this block
// Operation
// RULE1: row length 0 means 1024 pixels
// RULE2: row buffers delay pixels by row length
// RULE3: row length 3 gives nine-tap filter
// RULE4: clear before rewriting the row length
// RULE5: two banks of nine 8-bit coefficients
// RULE6: one bank active, chosen by select write
// RULE7: nine writes fill a bank A to I
// RULE8: data latched when either strobe rises
// RULE9: codes 000 row length, 001 ALU command
// RULE10: 010/011 coefficient banks, 100 initialization
// RULE11: 101/110 select bank, 111 does nothing
// RULE12: registers sampled on the clock edge
// RULE13: strobe released before the clock edge
// RULE14: bank switch loses no clock cycles
// RULE15: bit0 clear adds cascade input to result
// RULE16: bit0 set feeds cascade halves to multipliers
// RULE17: cascade input shifted by 0/2/4/8
// RULE18: shifted cascade summed into 20-bit result
// RULE19: cascade output is two-row-delayed pixels
// RULE20: bits 8:7 encode 00,01,10,11 shift
// RULE21: master clear defaults, frame clear keeps
// RULE22: master clear zeroes banks, selects zero
// RULE23: select and no-op writes store nothing
// RULE24: bank write leaves active bank unchanged
`include "cvl_cfg.svh"

module cvl_dev (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_frame_clear,
	cvl_if.dev bus,
	input wire logic [7:0] i_pixel,
	input wire logic [15:0] i_cascade_input,
	input wire logic [19:0] i_kernel_sum,
	output logic [7:0] o_pixel_bottom,
	output logic [7:0] o_pixel_mid,
	output logic [7:0] o_pixel_top,
	output logic [71:0] o_coef_active,
	output logic o_active_bank,
	output logic [9:0] o_alu_command,
	output logic [8:0] o_init_config,
	output logic [7:0] o_cascade_output,
	output logic [19:0] o_result_output
);
	// Control registers
	logic [9:0] row_length_reg_q;
	logic [9:0] alu_command_reg_q;
	logic [8:0] init_config_q;
	logic rl_loaded_q;
	logic bank_sel_q;
	cvl_pkg::cvl_pix_t coef_bank_q [2][`CVL_KERNEL_TAPS];

	// Write port capture
	logic wr_act_q;
	cvl_pkg::cvl_addr_t cap_addr_q;
	cvl_pkg::cvl_data_t cap_data_q;
	logic coef_run_q;
	cvl_pkg::cvl_addr_t run_addr_q;
	logic [3:0] idx_q;

	// Row buffers
	cvl_pkg::cvl_pix_t row_mem0 [1024];
	cvl_pkg::cvl_pix_t row_mem1 [1024];
	logic [9:0] wptr_q;

	// Output registers
	logic [71:0] coef_out_q;
	cvl_pkg::cvl_pix_t bottom_q;
	cvl_pkg::cvl_pix_t mid_q;
	cvl_pkg::cvl_pix_t top_q;
	cvl_pkg::cvl_pix_t caso_q;
	logic [19:0] result_q;

	// RULE8 write completes as strobes rise
	wire wr_act = !bus.chip_select_n && !bus.load_strobe_n;
	wire commit = wr_act_q && !wr_act;

	// RULE9 address decode
	wire wr_row_len = commit && (cap_addr_q == `CVL_ADDR_ROW_LEN);
	wire wr_alu = commit && (cap_addr_q == `CVL_ADDR_ALU_CMD);
	// RULE10 bank and init decode
	wire wr_coef0 = commit && (cap_addr_q == `CVL_ADDR_COEF0);
	wire wr_coef1 = commit && (cap_addr_q == `CVL_ADDR_COEF1);
	wire wr_init = commit && (cap_addr_q == `CVL_ADDR_INIT);
	// RULE11 select decode, no-op has no term
	wire wr_sel0 = commit && (cap_addr_q == `CVL_ADDR_SEL0);
	wire wr_sel1 = commit && (cap_addr_q == `CVL_ADDR_SEL1);
	wire wr_coef = wr_coef0 || wr_coef1;

	// RULE7 next kernel position
	wire same_run = coef_run_q && (run_addr_q == cap_addr_q);
	wire [3:0] cur_idx = same_run ? idx_q : 4'h0;
	wire last_tap = (cur_idx == `CVL_LAST_TAP);

	// RULE1 zero wraps to a 1024 delay
	wire [9:0] rd_ptr = wptr_q - row_length_reg_q;
	// RULE2 one row of delay per buffer
	wire [7:0] row1_d = row_mem0[rd_ptr];
	wire [7:0] row2_d = row_mem1[rd_ptr];

	wire cascade_mode = init_config_q[`CVL_INIT_CASCADE_MODE];
	wire [1:0] shift_sel = init_config_q[`CVL_INIT_SHIFT_HI:`CVL_INIT_SHIFT_LO];
	wire [19:0] cas_ext = {4'h0, i_cascade_input};
	logic [19:0] cas_shifted;

	// RULE17 cascade shift
	// RULE20 shift encoding
	always_comb begin
		case (shift_sel)
			2'h0: cas_shifted = cas_ext;
			2'h1: cas_shifted = cas_ext << 2;
			2'h2: cas_shifted = cas_ext << 4;
			default: cas_shifted = cas_ext << 8;
		endcase
	end

	// RULE15 adder only in sum mode
	wire [19:0] cas_addend = cascade_mode ? 20'h00000 : cas_shifted;
	// RULE16 external buffers replace internal rows
	wire [7:0] mid_sel = cascade_mode ? i_cascade_input[7:0] : row1_d;
	wire [7:0] top_sel = cascade_mode ? i_cascade_input[15:8] : row2_d;

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			wr_act_q <= 1'b0;
			cap_addr_q <= `CVL_ADDR_NOP;
			cap_data_q <= 10'h000;
		end else begin
			wr_act_q <= wr_act;
			if (wr_act) begin
				cap_addr_q <= bus.register_address;
				cap_data_q <= bus.config_input_bus;
			end
		end
	end

	// RULE21 master clear loads defaults only
	// RULE12 registers change on the clock edge
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			row_length_reg_q <= `CVL_ROW_LEN_RST;
			alu_command_reg_q <= `CVL_ALU_CMD_RST;
			init_config_q <= `CVL_INIT_RST;
			rl_loaded_q <= 1'b0;
		end else begin
			// RULE4 later row length ignored until clear
			if (wr_row_len && !rl_loaded_q) begin
				row_length_reg_q <= cap_data_q;
				rl_loaded_q <= 1'b1;
			end
			if (wr_alu) begin
				alu_command_reg_q <= cap_data_q;
			end
			if (wr_init) begin
				init_config_q <= cap_data_q[8:0];
			end
		end
	end

	// RULE6 only select writes move the bank
	// RULE24 coefficient loads leave selection alone
	// RULE23 select writes ignore the data bus
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			// RULE22 bank zero active after clear
			bank_sel_q <= 1'b0;
		end else if (wr_sel0) begin
			bank_sel_q <= 1'b0;
		end else if (wr_sel1) begin
			bank_sel_q <= 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			coef_run_q <= 1'b0;
			run_addr_q <= `CVL_ADDR_NOP;
			idx_q <= 4'h0;
		end else if (wr_coef) begin
			coef_run_q <= !last_tap;
			run_addr_q <= cap_addr_q;
			idx_q <= last_tap ? 4'h0 : cur_idx + 4'h1;
		end else if (commit) begin
			// Any other write restarts the next burst at A
			coef_run_q <= 1'b0;
		end
	end

	// RULE5 two banks of nine coefficients
	for (genvar b = 0; b < 2; b++) begin : g_bank
		for (genvar e = 0; e < `CVL_KERNEL_TAPS; e++) begin : g_tap
			wire hit = (b == 0 ? wr_coef0 : wr_coef1) && (cur_idx == 4'(e));
			always_ff @(posedge i_core_clk) begin
				if (i_reset) begin
					coef_bank_q[b][e] <= `CVL_COEF_RST;
				end else if (hit) begin
					coef_bank_q[b][e] <= cap_data_q[7:0];
				end
			end
		end
	end

	// RULE14 whole kernel swaps in one edge
	for (genvar e = 0; e < `CVL_KERNEL_TAPS; e++) begin : g_coef_out
		always_ff @(posedge i_core_clk) begin
			if (i_reset) begin
				coef_out_q[e*8 +: 8] <= `CVL_COEF_RST;
			end else begin
				coef_out_q[e*8 +: 8] <= bank_sel_q ? coef_bank_q[1][e] : coef_bank_q[0][e];
			end
		end
	end

	// Memories carry no reset; frame clear restarts the pointer and zeroes the pixel, cascade and result output registers, not coef_out_q
	always_ff @(posedge i_core_clk) begin
		row_mem0[wptr_q] <= i_pixel;
		row_mem1[wptr_q] <= row1_d;
	end

	// RULE3 length 3 makes rows adjacent taps
	always_ff @(posedge i_core_clk) begin
		if (i_reset || i_frame_clear) begin
			wptr_q <= 10'h000;
			bottom_q <= 8'h00;
			mid_q <= 8'h00;
			top_q <= 8'h00;
			caso_q <= 8'h00;
			result_q <= 20'h00000;
		end else begin
			wptr_q <= wptr_q + 10'h001;
			bottom_q <= i_pixel;
			mid_q <= mid_sel;
			top_q <= top_sel;
			// RULE19 second buffer feeds cascade output
			caso_q <= row2_d;
			// RULE18 cascade term into 20-bit sum
			result_q <= i_kernel_sum + cas_addend;
		end
	end

	assign o_pixel_bottom = bottom_q;
	assign o_pixel_mid = mid_q;
	assign o_pixel_top = top_q;
	assign o_coef_active = coef_out_q;
	assign o_active_bank = bank_sel_q;
	assign o_alu_command = alu_command_reg_q;
	assign o_init_config = init_config_q;
	assign o_cascade_output = caso_q;
	assign o_result_output = result_q;
endmodule // cvl_dev

/* src/cvl_host.sv */
// Purpose: processor end writing convolver control registers
// Assumes: i_reset is also the convolver master clear
// Notes: one write per request; row length refused until next clear
`include "cvl_cfg.svh"

module cvl_host (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_wr_valid,
	input wire logic [2:0] i_wr_addr,
	input wire logic [9:0] i_wr_data,
	output logic o_wr_ready,
	output logic o_wr_done,
	output logic o_refused,
	cvl_if.host bus
);
	cvl_pkg::cvl_host_state_e state_q;
	cvl_pkg::cvl_addr_t addr_q;
	cvl_pkg::cvl_data_t data_q;
	logic strobe_n_q;
	logic [2:0] cnt_q;
	logic rl_done_q;
	logic ready_q;
	logic done_q;
	logic refused_q;

	wire take = i_wr_valid && ready_q;
	wire is_row_len = (i_wr_addr == `CVL_ADDR_ROW_LEN);
	// RULE4 no second row length
	wire refuse = take && is_row_len && rl_done_q;
	wire cnt_end = (state_q == cvl_pkg::CVL_SETUP) ? (cnt_q == `CVL_SETUP_CYC - 3'h1)
		: (cnt_q == `CVL_STROBE_CYC - 3'h1);

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state_q <= cvl_pkg::CVL_IDLE;
			addr_q <= `CVL_ADDR_NOP;
			data_q <= 10'h000;
			strobe_n_q <= 1'b1;
			cnt_q <= 3'h0;
			rl_done_q <= 1'b0;
			ready_q <= 1'b1;
			done_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			refused_q <= refuse;
			case (state_q)
				cvl_pkg::CVL_IDLE: begin
					// RULE8 address and data first
					if (take && !refuse) begin
						addr_q <= i_wr_addr;
						data_q <= i_wr_data;
						cnt_q <= 3'h0;
						ready_q <= 1'b0;
						state_q <= cvl_pkg::CVL_SETUP;
						if (is_row_len) begin
							rl_done_q <= 1'b1;
						end
					end
				end
				cvl_pkg::CVL_SETUP: begin
					cnt_q <= cnt_q + 3'h1;
					if (cnt_end) begin
						cnt_q <= 3'h0;
						strobe_n_q <= 1'b0;
						state_q <= cvl_pkg::CVL_STROBE;
					end
				end
				cvl_pkg::CVL_STROBE: begin
					cnt_q <= cnt_q + 3'h1;
					// RULE13 release well before edge
					if (cnt_end) begin
						strobe_n_q <= 1'b1;
						state_q <= cvl_pkg::CVL_HOLD;
					end
				end
				cvl_pkg::CVL_HOLD: begin
					// RULE7 address held over a burst
					done_q <= 1'b1;
					ready_q <= 1'b1;
					state_q <= cvl_pkg::CVL_IDLE;
				end
				default: begin
					state_q <= cvl_pkg::CVL_IDLE;
				end
			endcase
		end
	end

	assign bus.register_address = addr_q;
	assign bus.config_input_bus = data_q;
	assign bus.chip_select_n = strobe_n_q;
	assign bus.load_strobe_n = strobe_n_q;
	assign o_wr_ready = ready_q;
	assign o_wr_done = done_q;
	assign o_refused = refused_q;
endmodule // cvl_host

/* test/convolver_control_and_cascade_tb_top.sv */
// Purpose: host and convolver back to back, driven by write requests
// Assumes: codes and reset values from cvl_cfg.svh
// Notes: free-running pixel ramp; outputs sampled on the falling edge
`include "cvl_cfg.svh"

module convolver_control_and_cascade_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, vld, fclr, wide, done, rdy, refd, bank;
	logic [2:0] wa;
	logic [9:0] wd, alu;
	logic [8:0] ini;
	logic [7:0] bot, mid, top, caso;
	logic [7:0] pix = 8'h00;
	logic [15:0] casi;
	logic [19:0] ksum, res;
	logic [71:0] coef, exp_coef;
	logic [10:0] cnt = 11'h000;
	int fail_count, cmp_count;

	cvl_if i_cvl_if ();
	cvl_host i_cvl_host (.i_core_clk(clk), .i_reset(rst), .i_wr_valid(vld), .i_wr_addr(wa),
		.i_wr_data(wd), .o_wr_ready(rdy), .o_wr_done(done), .o_refused(refd),
		.bus(i_cvl_if.host));
	cvl_dev i_cvl_dev (.i_core_clk(clk), .i_reset(rst), .i_frame_clear(fclr),
		.bus(i_cvl_if.dev), .i_pixel(pix), .i_cascade_input(casi), .i_kernel_sum(ksum),
		.o_pixel_bottom(bot), .o_pixel_mid(mid), .o_pixel_top(top), .o_coef_active(coef),
		.o_active_bank(bank), .o_alu_command(alu), .o_init_config(ini),
		.o_cascade_output(caso), .o_result_output(res));
	cvl_monitor i_cvl_monitor (.i_core_clk(clk), .i_reset(rst),
		.register_address(i_cvl_if.register_address),
		.config_input_bus(i_cvl_if.config_input_bus),
		.chip_select_n(i_cvl_if.chip_select_n), .load_strobe_n(i_cvl_if.load_strobe_n));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Slow ramp in wide mode so a 1024 delay stays visible in 8 bits
	always @(posedge clk) begin
		cnt <= cnt + 11'h001;
		pix <= wide ? cnt[10:3] : cnt[7:0];
	end

	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
	endtask

	task automatic wr(input logic [2:0] a, input logic [9:0] d, input logic exp_ref);
		int n;
		@(posedge clk);
		wa <= a;
		wd <= d;
		vld <= 1'b1;
		@(posedge clk);
		vld <= 1'b0;
		for (n = 0; n < 8; n++) begin
			@(negedge clk);
			if (done === 1'b1 || refd === 1'b1) break;
		end
		if (n == 8) begin
			fail_count++;
			complete_run();
		end else begin
			check(refd, exp_ref);
			check(rdy, 1'b1);
			// Coefficients show one edge after the commit
			@(negedge clk);
		end
	endtask

	initial begin
		rst = 1'b1;
		vld = 1'b0;
		fclr = 1'b0;
		wide = 1'b0;
		wa = 3'h0;
		wd = 10'h000;
		casi = 16'h0000;
		ksum = 20'h00000;
		fail_count = 0;
		cmp_count = 0;
		do_reset();
		check(alu, `CVL_ALU_CMD_RST);
		check({ini, bank, coef}, 82'h0);
		$display("test reset done");
		wr(`CVL_ADDR_ALU_CMD, 10'h3A5, 1'b0);
		check(alu, 10'h3A5);
		exp_coef = 72'h0;
		for (int k = 0; k < 9; k++) begin
			wr(`CVL_ADDR_COEF1, {2'h3, 4'h1, 4'(k)}, 1'b0);
			exp_coef[8*k +: 8] = {4'h1, 4'(k)};
		end
		check(coef, 72'h0);
		wr(`CVL_ADDR_SEL1, 10'h3FF, 1'b0);
		check(bank, 1'b1);
		check(coef, exp_coef);
		check(alu, 10'h3A5);
		wr(`CVL_ADDR_NOP, 10'h155, 1'b0);
		check({alu, ini, bank, coef}, {10'h3A5, 9'h000, 1'b1, exp_coef});
		wr(`CVL_ADDR_SEL0, 10'h000, 1'b0);
		check(coef, 72'h0);
		$display("test registers done");
		for (int s = 0; s < 4; s++) begin
			wr(`CVL_ADDR_INIT, {1'b0, s[1:0], 7'h00}, 1'b0);
			@(posedge clk);
			casi <= 16'h8001 + 16'(s);
			ksum <= 20'hF1234;
			repeat (2) @(negedge clk);
			check(res, 20'(20'hF1234 + (20'(16'h8001 + 16'(s)) << ((s == 3) ? 8 : 2 * s))));
		end
		wr(`CVL_ADDR_INIT, 10'h001, 1'b0);
		check({top, mid}, casi);
		check(res, 20'hF1234);
		check(ini, 9'h001);
		$display("test cascade done");
		wr(`CVL_ADDR_ROW_LEN, 10'h003, 1'b0);
		wr(`CVL_ADDR_INIT, 10'h000, 1'b0);
		repeat (12) @(negedge clk);
		check(bot, 8'(cnt[7:0] - 8'h02));
		check(mid, 8'(cnt[7:0] - 8'h05));
		check(top, 8'(cnt[7:0] - 8'h08));
		check(caso, 8'(cnt[7:0] - 8'h08));
		wr(`CVL_ADDR_ROW_LEN, 10'h005, 1'b1);
		repeat (12) @(negedge clk);
		check(mid, 8'(cnt[7:0] - 8'h05));
		$display("test row length done");
		@(posedge clk);
		wide <= 1'b1;
		do_reset();
		check(alu, `CVL_ALU_CMD_RST);
		wr(`CVL_ADDR_ROW_LEN, 10'h000, 1'b0);
		wr(`CVL_ADDR_SEL1, 10'h000, 1'b0);
		check({bank, coef}, {1'b1, 72'h0});
		repeat (2100) @(negedge clk);
		check(mid, 8'(11'(cnt - 11'h402) >> 3));
		check(top, 8'(11'(cnt - 11'h002) >> 3));
		check(caso, 8'(11'(cnt - 11'h002) >> 3));
		wr(`CVL_ADDR_ALU_CMD, 10'h2C3, 1'b0);
		@(posedge clk);
		fclr <= 1'b1;
		@(posedge clk);
		fclr <= 1'b0;
		@(negedge clk);
		check({bot, mid, top, caso, res}, 52'h0);
		check({alu, bank}, {10'h2C3, 1'b1});
		$display("test long row and frame clear done");
		complete_run();
	end
endmodule // convolver_control_and_cascade_tb_top

/* test/cvl_monitor.sv */
// Purpose: checks on the write port wires between host and convolver
// Assumes: one clock, synchronous active-high reset
// Notes: sees only what the host end drives
module cvl_monitor (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [2:0] register_address,
	input wire logic [9:0] config_input_bus,
	input wire logic chip_select_n,
	input wire logic load_strobe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic row_done_q;

	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);

	// Only a master clear allows another row length
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			row_done_q <= 1'b0;
		end else if ($rose(load_strobe_n) && register_address == 3'h0) begin
			row_done_q <= 1'b1;
		end
	end

	AST_STROBE_PAIR: assert property (chip_select_n == load_strobe_n)
		else $error("select and load strobe differ");
	AST_SETUP: assert property ($fell(load_strobe_n) |->
		$stable(register_address) && $stable(config_input_bus))
		else $error("address or data moved as strobe fell");
	AST_HOLD: assert property (!load_strobe_n && !$past(load_strobe_n) |->
		$stable(register_address) && $stable(config_input_bus))
		else $error("address or data moved while strobed");
	AST_LOW_TWO: assert property ($fell(load_strobe_n) |=>
		!load_strobe_n ##1 load_strobe_n)
		else $error("strobe low time wrong");
	AST_GAP: assert property ($rose(load_strobe_n) |=> load_strobe_n)
		else $error("strobe reasserted too soon");
	AST_ROW_ONCE: assert property ($rose(load_strobe_n) && register_address == 3'h0
		|-> !row_done_q)
		else $error("row length rewritten without clear");

	cover property ($rose(load_strobe_n) && register_address == 3'h3);
	cover property ($rose(load_strobe_n) && register_address == 3'h6);
	cover property ($rose(load_strobe_n) && register_address == 3'h0);
endmodule // cvl_monitor
